/* File: logic/fault_response_manager.sv */
/*
  Fault response manager: decides gate drive enables, fault latching,
  fault clearing and output re-enable, with an APB register file.
  Assumes fault pins are asynchronous levels, PWM on-time flags come from
  logic on the same clock, and the APB master keeps the bus protocol.
*/
// The placing of the registers and the APB slave port were left to the implementer.
`include "fault_response_consts.svh"

// Function
// (R1) Full disable drives every gate low.
// (R2) Bootstrap/VDS: affected gate off, restore on PWM.
// (R3) Status read clears latches only if inhibit 0.
// (R4) Demand zero then nonzero re-enables outputs.
// (R5) Go zero then one re-enables outputs.
// (R6) Supply POR: outputs off, logic reset, go needed.
// (R7) Main undervoltage: outputs on; latch per restart control.
// (R8) Logic undervoltage: off, host reset, 10 ms hold.
// (R9) Sync loss: latch or restart per restart control.
// (R10) Enable only without active or pending fault.
// (R11) System error: off, latch, clear go.
module fault_response_manager #(
  parameter int HOLD_CYCLES = `FRM_HOLD_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fault pins, asynchronous.
  input  wire logic        sysErrorPin,
  input  wire logic        mainPorPin,
  input  wire logic        mainUvPin,
  input  wire logic        logicUvPin,
  input  wire logic        gateUvPin,
  input  wire logic        syncLossPin,
  input  wire logic [5:0]  bootUvPin,
  input  wire logic [5:0]  vdsOvPin,
  // PWM on-time start per transistor, same clock.
  input  wire logic [5:0]  pwmOn,
  // Outputs.
  output logic [5:0]       gateEnable,
  output logic             host_reset_n,
  output logic             restartPulse,
  output logic             irq
);

  // -----------------------------------------------------------------------
  // Declarations.
  // -----------------------------------------------------------------------
  fault_response_pkg::fault_pins_t pins;      // Synchronised fault levels.
  fault_response_pkg::host_state_t host_reg;  // Host reset sequencer.
  hold_timer_if                    holdBus (); // Hold timer carrier.
  logic        go_reg;          // Drive-go bit.
  logic        rsc_reg;         // Restart control bit.
  logic        inhibit_reg;     // Status-reset-inhibit bit.
  logic [7:0]  demand_reg;      // Demand value.
  logic [7:0]  status_reg;      // Sticky event bits.
  logic [7:0]  status_next;     // Next sticky bits.
  logic [7:0]  mask_reg;        // Interrupt mask.
  logic        demandZero_reg;  // Demand was seen at zero.
  logic        goZero_reg;      // Go was seen at zero.
  logic        latMainUv_reg;   // Latched main undervoltage.
  logic        latSync_reg;     // Latched sync loss.
  logic        latLogic_reg;    // Latched logic undervoltage.
  logic        latSys_reg;      // Latched system error.
  logic        pending_reg;     // Latched fault awaits re-enable event.
  logic [5:0]  partOff_reg;     // Per-gate off after bootstrap or VDS fault.
  localparam logic [31:0] CtrlRst = `FRM_CTRL_RST; // Control reset word.
  logic [7:0]  events;          // Rising fault events this cycle.
  logic [7:0]  levelPrev_reg;   // Fault levels last cycle.
  logic [7:0]  levels;          // Fault levels now.
  logic        access;          // APB access completes this cycle.
  logic        wrCtrl;          // Control register write.
  logic        rdStatus;        // Status register read.
  logic        serialClear;     // Permitted serial clear.
  logic        demandReset;     // Demand zero-then-nonzero event.
  logic        runReset;        // Go zero-then-one event.
  logic        reEnable;        // Any accepted re-enable event.
  logic        softReset;       // Internal logic reset on supply POR.
  logic        globalOff;       // All outputs must be off.
  logic [7:0]  newDemand;       // Demand field of a control write.
  logic        newGo;           // Go field of a control write.

  pin_sync #(
    .WIDTH (18)
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pinIn   ({sysErrorPin, mainPorPin, mainUvPin, logicUvPin, gateUvPin,
               syncLossPin, bootUvPin, vdsOvPin}),
    .pinOut  (pins)
  );

  hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clock   (clock),
    .reset_n (reset_n),
    .tmr     (holdBus.timer)
  );

  // -----------------------------------------------------------------------
  // Bus decode and sequence events.
  // -----------------------------------------------------------------------
  assign access    = psel && penable && pready;
  assign wrCtrl    = access && pwrite && (paddr == `FRM_CTRL_OFS);
  assign rdStatus  = access && !pwrite && (paddr == `FRM_STATUS_OFS);
  assign newDemand = pwdata[`FRM_DEMAND_MSB:`FRM_DEMAND_LSB];
  assign newGo     = pwdata[`FRM_GO_BIT];
  // (R3) Clear honoured when uninhibited.
  assign serialClear = rdStatus && !inhibit_reg;
  // (R4) Demand reset sequence.
  assign demandReset = wrCtrl && demandZero_reg && (newDemand != 8'h00);
  // (R5) Run reset sequence.
  assign runReset    = wrCtrl && goZero_reg && newGo;
  assign reEnable    = demandReset || runReset || serialClear;
  // (R6) Supply POR resets logic.
  assign softReset   = pins.mainPor;

  // Fault levels packed in status layout.
  assign levels = {pins.syncLoss, |pins.vdsOv, |pins.bootUv, pins.gateUv,
                   pins.logicUv, pins.mainUv, pins.mainPor, pins.sysError};
  assign events = levels & ~levelPrev_reg;

  // Level history: fault edges, the zero halves of the demand and run
  // sequences, and the one-cycle restart request on sync loss.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      levelPrev_reg  <= 8'h00;
      demandZero_reg <= 1'b1;
      goZero_reg     <= 1'b1;
      restartPulse   <= 1'b0;
    end else begin
      levelPrev_reg  <= levels;
      demandZero_reg <= (demand_reg == 8'h00);
      goZero_reg     <= !go_reg;
      // (R9) Stop and restart under restart control 1.
      restartPulse   <= pins.syncLoss && !levelPrev_reg[7] && rsc_reg;
    end
  end

  // -----------------------------------------------------------------------
  // APB handshake: one wait state, registered answer.
  // -----------------------------------------------------------------------
  // Raise ready one cycle into the access phase, drop after completion.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= (paddr[7:4] != 4'h0) || (paddr[1:0] != 2'b00);
      unique case (paddr)
        `FRM_CTRL_OFS:   prdata <= {16'h0000, demand_reg, 5'b00000,
                                    inhibit_reg, rsc_reg, go_reg};
        `FRM_STATUS_OFS: prdata <= {24'h000000, status_reg};
        `FRM_MASK_OFS:   prdata <= {24'h000000, mask_reg};
        `FRM_STATE_OFS:  prdata <= {16'h0000, 2'b00, gateEnable,
                                    3'b000, pending_reg, latSys_reg,
                                    latLogic_reg, latSync_reg, latMainUv_reg};
        default:         prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software writes control; supply POR and system error override go.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      go_reg      <= CtrlRst[`FRM_GO_BIT];
      rsc_reg     <= CtrlRst[`FRM_RSC_BIT];
      inhibit_reg <= CtrlRst[`FRM_INHIBIT_BIT];
      demand_reg  <= CtrlRst[`FRM_DEMAND_MSB:`FRM_DEMAND_LSB];
    end else if (softReset) begin
      // (R6) Internal logic reset.
      go_reg      <= 1'b0;
      rsc_reg     <= 1'b0;
      inhibit_reg <= 1'b0;
      demand_reg  <= 8'h00;
    end else begin
      if (wrCtrl) begin
        rsc_reg     <= pwdata[`FRM_RSC_BIT];
        inhibit_reg <= pwdata[`FRM_INHIBIT_BIT];
        demand_reg  <= newDemand;
      end
      // (R11) System error clears go.
      if (pins.sysError) begin
        go_reg <= 1'b0;
      end else if (wrCtrl) begin
        go_reg <= newGo;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Status, mask and interrupt.
  // -----------------------------------------------------------------------
  // New events win over a write-one clear in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (access && pwrite && (paddr == `FRM_STATUS_OFS)) begin
      status_next = status_next & ~pwdata[7:0];
    end
    status_next = status_next | events;
  end

  // Sticky status, mask, and a level interrupt while an unmasked bit is set.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= 8'h00;
      mask_reg   <= `FRM_MASK_RST;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
      if (access && pwrite && (paddr == `FRM_MASK_OFS)) begin
        mask_reg <= pwdata[7:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Latched fault states and gate enables.
  // -----------------------------------------------------------------------
  // Main undervoltage latches only with restart control at zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latMainUv_reg <= 1'b0;
    end else if (softReset) begin
      latMainUv_reg <= 1'b0;
    end else if (pins.mainUv && !rsc_reg) begin
      // (R7) Latch with restart control 0.
      latMainUv_reg <= 1'b1;
    end else if ((demand_reg == 8'h00) || !go_reg || serialClear) begin
      // (R7) Demand, go or serial clear.
      latMainUv_reg <= 1'b0;
    end
  end

  // Sync loss latches with restart control at zero.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latSync_reg <= 1'b0;
    end else if (softReset) begin
      latSync_reg <= 1'b0;
    end else if (pins.syncLoss && !rsc_reg) begin
      // (R9) Latch with restart control 0.
      latSync_reg <= 1'b1;
    end else if ((demand_reg == 8'h00) || !go_reg || serialClear) begin
      latSync_reg <= 1'b0;
    end
  end

  // System error holds until power-on reset only.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latSys_reg <= 1'b0;
    end else if (softReset) begin
      latSys_reg <= 1'b0;
    end else if (pins.sysError) begin
      // (R11) Latch until POR.
      latSys_reg <= 1'b1;
    end
  end

  // The hold interval runs only once the logic supply is back.
  assign holdBus.arm = (host_reg == fault_response_pkg::HR_HOLD) && !pins.logicUv;

  // Assert host reset on undervoltage, hold it after recovery.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_reg     <= fault_response_pkg::HR_RUN;
      host_reset_n <= 1'b1;
      latLogic_reg <= 1'b0;
    end else begin
      unique case (host_reg)
        fault_response_pkg::HR_RUN: begin
          if (pins.logicUv) begin
            // (R8) Latch and reset host.
            host_reg     <= fault_response_pkg::HR_ASSERT;
            host_reset_n <= 1'b0;
            latLogic_reg <= 1'b1;
          end
        end
        fault_response_pkg::HR_ASSERT: begin
          if (!pins.logicUv) begin
            host_reg <= fault_response_pkg::HR_HOLD;
          end
        end
        fault_response_pkg::HR_HOLD: begin
          if (pins.logicUv) begin
            host_reg <= fault_response_pkg::HR_ASSERT;
          end else if (holdBus.done) begin
            // (R8) Release after hold interval.
            host_reg     <= fault_response_pkg::HR_RUN;
            host_reset_n <= 1'b1;
            latLogic_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Set by sync loss or logic undervoltage with restart control 0; cleared by supply POR or by a re-enable event while the sync and logic latches are clear.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
    end else if (softReset) begin
      pending_reg <= 1'b0;
    end else if ((pins.syncLoss || pins.logicUv) && !rsc_reg) begin
      // (R10) Await re-enable sequence.
      pending_reg <= 1'b1;
    end else if (reEnable && !latSync_reg && !latLogic_reg) begin
      pending_reg <= 1'b0;
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_part
    // Off on the fault; back on at the next PWM on-time once it is gone.
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        partOff_reg[g] <= 1'b0;
      end else if (pins.bootUv[g] || pins.vdsOv[g]) begin
        // (R2) Affected gate only.
        partOff_reg[g] <= 1'b1;
      end else if (pwmOn[g]) begin
        // (R2) Restore at PWM on.
        partOff_reg[g] <= 1'b0;
      end
    end
  end

  // Main undervoltage is deliberately absent: outputs stay on through it.
  assign globalOff = pins.sysError || pins.mainPor || pins.logicUv ||
                     pins.gateUv || pins.syncLoss || latSync_reg ||
                     latLogic_reg || pending_reg || (host_reg !=
                     fault_response_pkg::HR_RUN);

  // Enable each gate only when nothing forbids it.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gateEnable <= 6'h00;
    end else if (globalOff || !go_reg || (demand_reg == 8'h00)) begin
      // (R1) All gates low.
      gateEnable <= 6'h00;
    end else begin
      // (R10) Enable when clean.
      gateEnable <= ~partOff_reg;
    end
  end

endmodule : fault_response_manager

/* File: logic/fault_response_consts.svh */
/*
  Offsets, field positions, reset values and timing counts of the fault
  response manager. Assumes it is included by bare name, once per unit.
*/
`ifndef FAULT_RESPONSE_CONSTS_SVH
`define FAULT_RESPONSE_CONSTS_SVH

// -----------------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------------
`define FRM_CTRL_OFS      8'h00
`define FRM_STATUS_OFS    8'h04
`define FRM_MASK_OFS      8'h08
`define FRM_STATE_OFS     8'h0c

// -----------------------------------------------------------------------
// Control register fields.
// -----------------------------------------------------------------------
`define FRM_GO_BIT        0
`define FRM_RSC_BIT       1
`define FRM_INHIBIT_BIT   2
`define FRM_DEMAND_LSB    8
`define FRM_DEMAND_MSB    15

// -----------------------------------------------------------------------
// Status and mask register fields.
// -----------------------------------------------------------------------
`define FRM_ST_SYS        0
`define FRM_ST_POR        1
`define FRM_ST_MAINUV     2
`define FRM_ST_LOGICUV    3
`define FRM_ST_GATEUV     4
`define FRM_ST_BOOT       5
`define FRM_ST_VDS        6
`define FRM_ST_SYNC       7
`define FRM_ST_WIDTH      8

// -----------------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------------
`define FRM_CTRL_RST      32'h0000_0000
`define FRM_MASK_RST      8'h00

// -----------------------------------------------------------------------
// Timing: host reset hold after logic supply recovery.
// -----------------------------------------------------------------------
`define FRM_CLK_MHZ       250
`define FRM_HOLD_MS       10
`define FRM_HOLD_CYCLES   (`FRM_HOLD_MS * `FRM_CLK_MHZ * 1000)

`endif

/* File: logic/fault_response_pkg.sv */
/*
  Types of the fault response manager.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fault_response_pkg;

  // Host reset sequencer states.
  typedef enum logic [1:0] {
    HR_RUN,
    HR_ASSERT,
    HR_HOLD
  } host_state_t;

  // Fault pins after synchronisation.
  typedef struct packed {
    logic       sysError;
    logic       mainPor;
    logic       mainUv;
    logic       logicUv;
    logic       gateUv;
    logic       syncLoss;
    logic [5:0] bootUv;
    logic [5:0] vdsOv;
  } fault_pins_t;

endpackage : fault_response_pkg

/* File: logic/hold_timer_if.sv */
/*
  Carrier between the main block and its hold timer.
  Assumes both ends share one clock.
*/
interface hold_timer_if;
  logic arm;   // High while the hold interval is to run.
  logic done;  // High once the interval has elapsed while armed.

  modport timer (input arm, output done);
  modport user  (output arm, input done);
endinterface : hold_timer_if

/* File: logic/pin_sync.sv */
/*
  Two-flop synchroniser bank for asynchronous fault pins.
  Assumes pins are levels that hold for several clock cycles.
*/
module pin_sync #(
  parameter int WIDTH = 18
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Pins in and synchronised levels out.
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  // First stage of each lane; read only by the second stage.
  logic [WIDTH-1:0] meta_reg;

  // -----------------------------------------------------------------------
  // One two-flop chain per lane.
  // -----------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    // Each lane samples its pin twice before anything reads it.
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        meta_reg[i] <= 1'b0;
        pinOut[i]   <= 1'b0;
      end else begin
        meta_reg[i] <= pinIn[i];
        pinOut[i]   <= meta_reg[i];
      end
    end
  end

endmodule : pin_sync

/* File: logic/hold_timer.sv */
/*
  Counts a fixed interval while armed and flags its end.
  Assumes arm falls to restart it.
*/
`include "fault_response_consts.svh"

module hold_timer #(
  parameter int HOLD_CYCLES = `FRM_HOLD_CYCLES
) (
  // Clock and reset.
  input  wire logic   clock,
  input  wire logic   reset_n,
  // Arm and done.
  hold_timer_if.timer tmr
);

  logic [31:0] count_reg;  // Cycles spent armed.

  // Count up while armed; clear when disarmed.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 32'h0000_0000;
      tmr.done  <= 1'b0;
    end else if (!tmr.arm) begin
      count_reg <= 32'h0000_0000;
      tmr.done  <= 1'b0;
    end else if (count_reg >= 32'(HOLD_CYCLES - 1)) begin
      tmr.done  <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

endmodule : hold_timer

/* File: testbench/fault_response_manager_properties.sv */
/*
  Port checker of the fault response manager.
  Assumes it is bound to fault_response_manager.
*/
module fault_response_manager_properties (
  // Clock and reset.
  input wire logic       clock,
  input wire logic       reset_n,
  // Bus and pins watched.
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       sysErrorPin,
  input wire logic       mainPorPin,
  input wire logic       logicUvPin,
  input wire logic       syncLossPin,
  input wire logic [5:0] bootUvPin,
  input wire logic [5:0] gateEnable,
  input wire logic       host_reset_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------
  // Steps of an access and of a held fault.
  // ---------------------------------------------------------------
  sequence waitState;
    psel && penable && !pready;
  endsequence
  sequence sysHeld;
    sysErrorPin [*4];
  endsequence

  wait_one_a: assert property (waitState |=> pready) else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  slverr_map_a: assert property (pready && paddr >= 8'h10 |-> pslverr) else $error("no slverr");
  sys_off_a: assert property (sysHeld |=> gateEnable == 6'h00) else $error("sys on");
  por_off_a: assert property (mainPorPin [*4] |=> gateEnable == 6'h00) else $error("por on");
  logic_off_a: assert property (logicUvPin [*4] |=> gateEnable == 6'h00 && !host_reset_n)
    else $error("logic uv on");
  sync_off_a: assert property (syncLossPin [*4] |=> gateEnable == 6'h00) else $error("sync on");
  boot_one_a: assert property ((|bootUvPin) [*4] |=> (gateEnable & bootUvPin) == 0)
    else $error("boot on");
endmodule : fault_response_manager_properties

bind fault_response_manager fault_response_manager_properties u_fault_response_manager_properties (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .sysErrorPin(sysErrorPin), .mainPorPin(mainPorPin),
  .logicUvPin(logicUvPin), .syncLossPin(syncLossPin), .bootUvPin(bootUvPin),
  .gateEnable(gateEnable), .host_reset_n(host_reset_n));

/* File: testbench/host_apb_model.sv */
/*
  Host model: APB master of the register file.
  Assumes the bench timeout ends a hung access.
*/
module host_apb_model (
  // Clock.
  input  wire logic        clock,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; released lines other than pwrite go to the inverse of their last value.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_apb_model

/* File: testbench/fault_response_manager_tb_top.sv */
/*
  Self-checking bench of the fault response manager.
  Assumes a 20-cycle hold in place of the long host reset hold.
*/
`include "fault_response_consts.svh"

module fault_response_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        sysErrorPin, mainPorPin, mainUvPin, logicUvPin, gateUvPin, syncLossPin;
  logic        host_reset_n, restartPulse;
  logic [7:0]  paddr, dem;
  logic [31:0] pwdata, prdata, q;
  logic [5:0]  bootUvPin, vdsOvPin, pwmOn, gateEnable;
  int          bad_count, compares, cycles, k;
  int          seed = 32'h72e98b1d;

  fault_response_manager #(.HOLD_CYCLES(20)) u_fault_response_manager (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysErrorPin(sysErrorPin), .mainPorPin(mainPorPin), .mainUvPin(mainUvPin),
    .logicUvPin(logicUvPin), .gateUvPin(gateUvPin), .syncLossPin(syncLossPin),
    .bootUvPin(bootUvPin), .vdsOvPin(vdsOvPin), .pwmOn(pwmOn), .gateEnable(gateEnable),
    .host_reset_n(host_reset_n), .restartPulse(restartPulse), .irq(irq));
  host_apb_model u_host_apb_model (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host_apb_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_host_apb_model.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // Control word from {inhibit, restart, go} and demand.
  function automatic logic [31:0] ctl(input logic [2:0] f, input logic [7:0] d);
    return {16'h0000, d, 5'h00, f};
  endfunction : ctl
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Hang guard.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    {reset_n, sysErrorPin, mainPorPin, mainUvPin, logicUvPin, gateUvPin, syncLossPin} = 0;
    {bootUvPin, vdsOvPin, pwmOn} = 0;
    {bad_count, compares, cycles} = 0;
    cyc(16);
    reset_n <= 1'b1;
    rd(`FRM_CTRL_OFS);
    chk("ctrl", q, `FRM_CTRL_RST);
    rd(8'h10);
    chk("unmapped", q, 32'h0);
    dem = 8'($random(seed)) | 8'h01;
    wr(`FRM_CTRL_OFS, ctl(3'h1, dem));
    cyc(2);
    chk("run", gateEnable, 6'h3f);
    for (int t = 0; t < 2; t++) begin
      k = $unsigned($random(seed)) % 6;
      if (t == 0) bootUvPin[k] <= 1'b1;
      else vdsOvPin[k] <= 1'b1;
      cyc(6);
      chk("one off", gateEnable, 6'h3f & ~(6'h01 << k));
      {bootUvPin, vdsOvPin} <= 12'h000;
      cyc(6);
      chk("await pwm", gateEnable, 6'h3f & ~(6'h01 << k));
      pwmOn[k] <= 1'b1;
      cyc(1);
      pwmOn <= 6'h00;
      cyc(4);
      chk("pwm on", gateEnable, 6'h3f);
    end
    mainUvPin <= 1'b1;
    cyc(6);
    chk("uv on", gateEnable, 6'h3f);
    wr(`FRM_MASK_OFS, 32'h4);
    cyc(2);
    chk("irq", irq, 1'b1);
    mainUvPin <= 1'b0;
    for (int t = 1; t >= 0; t--) begin
      wr(`FRM_CTRL_OFS, ctl({t[0], 2'h1}, dem));
      rd(`FRM_STATUS_OFS);
      rd(`FRM_STATE_OFS);
      chk("uv latch", q[0], t[0]);
    end
    wr(`FRM_STATUS_OFS, 32'h4);
    cyc(2);
    chk("irq clr", irq, 1'b0);
    for (int t = 0; t < 2; t++) begin
      syncLossPin <= 1'b1;
      cyc(6);
      syncLossPin <= 1'b0;
      cyc(6);
      chk("sync latch", gateEnable, 6'h00);
      wr(`FRM_CTRL_OFS, t == 0 ? ctl(3'h1, 8'h00) : ctl(3'h0, dem));
      wr(`FRM_CTRL_OFS, ctl(3'h1, dem));
      cyc(3);
      chk("reenable", gateEnable, 6'h3f);
    end
    wr(`FRM_CTRL_OFS, ctl(3'h3, dem));
    syncLossPin <= 1'b1;
    cyc(4);
    chk("restart", restartPulse, 1'b1);
    cyc(2);
    chk("restart off", gateEnable, 6'h00);
    syncLossPin <= 1'b0;
    cyc(6);
    chk("restart on", gateEnable, 6'h3f);
    wr(`FRM_CTRL_OFS, ctl(3'h1, dem));
    logicUvPin <= 1'b1;
    cyc(6);
    chk("host rst", host_reset_n, 1'b0);
    logicUvPin <= 1'b0;
    cyc(12);
    chk("hold", host_reset_n, 1'b0);
    for (int n = 0; n < 40 && host_reset_n !== 1'b1; n++) cyc(1);
    chk("host run", host_reset_n, 1'b1);
    chk("pending", gateEnable, 6'h00);
    rd(`FRM_STATUS_OFS);
    cyc(3);
    chk("serial clr", gateEnable, 6'h3f);
    sysErrorPin <= 1'b1;
    cyc(6);
    sysErrorPin <= 1'b0;
    chk("sys off", gateEnable, 6'h00);
    rd(`FRM_CTRL_OFS);
    chk("go clr", q[0], 1'b0);
    mainPorPin <= 1'b1;
    cyc(6);
    mainPorPin <= 1'b0;
    cyc(4);
    rd(`FRM_CTRL_OFS);
    chk("por ctrl", q, `FRM_CTRL_RST);
    wr(`FRM_CTRL_OFS, ctl(3'h1, dem));
    cyc(3);
    chk("go again", gateEnable, 6'h3f);
    test_done();
  end
endmodule : fault_response_manager_tb_top
